// ===== src/rxec_map.svh
`ifndef RXEC_MAP_SVH
`define RXEC_MAP_SVH
// Buffer geometry: one entry per decoded character
`define RXEC_DEPTH      128
`define RXEC_ADDR_W     7
`define RXEC_HALF       64
`define RXEC_TOL        1
// Code group values after 8B/10B decoding
`define RXEC_K28_5      8'hBC
`define RXEC_D16_2      8'h50
`define RXEC_K27_7      8'hFB
`define RXEC_K29_7      8'hFD
// Reset values
`define RXEC_PTR_RST    8'h00
`define RXEC_CHAR_RST   9'h000
`endif

// ===== src/rxec_pkg.sv
package rxec_pkg;
   // One decoded character: control flag plus byte
   typedef struct packed {
      logic       is_k;
      logic [7:0] data;
   } rxec_char_t;

   // Read side: pass stored characters or insert an idle pair
   typedef enum logic [1:0] {
      RD_PASS  = 2'b00,
      RD_INS_K = 2'b01,
      RD_INS_D = 2'b10
   } rxec_rd_state_t;
endpackage

// ===== src/rxec_stream_if.sv
`timescale 1ns/1ns
interface rxec_stream_if;
   rxec_pkg::rxec_char_t chr;
   logic                 valid;
   logic                 ready;
   modport src (output chr, output valid, input ready);
   modport snk (input chr, input valid, output ready);
endinterface

// ===== src/rxec_skid.sv
`timescale 1ns/1ns
`include "rxec_map.svh"
module rxec_skid (
   input  wire logic                 clk,       // System clock
   input  wire logic                 reset_n,   // Synchronous reset, active low
   rxec_stream_if.snk                in_s,      // Characters from the buffer
   output rxec_pkg::rxec_char_t      out_char,  // Head entry
   output logic                      out_valid, // Head entry holds a character
   input  wire logic                 out_ready  // Receiver takes the head
);
   import rxec_pkg::*;

   rxec_char_t ent_reg [2];
   logic [1:0] cnt_reg;
   logic       vld_reg;
   logic       push;
   logic       pop;

   ////////////////////////////////////////////////////////////////////////////
   // Handshake terms
   assign in_s.ready = (cnt_reg != 2'h2);
   assign push       = in_s.valid && in_s.ready;
   assign pop        = out_valid && out_ready;
   assign out_char   = ent_reg[0];
   assign out_valid  = vld_reg;

   // Entry count; the head flag has its own flip-flop so the output is registered
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cnt_reg <= 2'h0;
         vld_reg <= 1'b0;
      end else if (push && !pop) begin
         cnt_reg <= cnt_reg + 2'h1;
         vld_reg <= 1'b1;
      end else if (pop && !push) begin
         cnt_reg <= cnt_reg - 2'h1;
         vld_reg <= (cnt_reg == 2'h2);
      end
   end

   // Entry storage, head always in entry 0
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ent_reg[0] <= `RXEC_CHAR_RST;
         ent_reg[1] <= `RXEC_CHAR_RST;
      end else begin
         if (pop) begin
            ent_reg[0] <= (cnt_reg == 2'h2) ? ent_reg[1] : in_s.chr;
         end else if (push && cnt_reg == 2'h0) begin
            ent_reg[0] <= in_s.chr;
         end
         if (push && ((cnt_reg == 2'h1 && !pop) || cnt_reg == 2'h2)) begin
            ent_reg[1] <= in_s.chr;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // A stalled head neither changes nor disappears
   a_skid_head_hold : assert property (@(posedge clk) disable iff (!reset_n)
      (out_valid && !out_ready) |=> (out_valid && out_char == $past(out_char)))
      else $error("head entry changed while stalled");
endmodule

// ===== src/rxec_elastic.sv
`timescale 1ns/1ns
`include "rxec_map.svh"
// Behaviour
// - In each gap, add or drop idle pairs to bring fill back near half.
// - After draining, insert as many idle pairs as needed, without limit.
// - Only /I2/ pairs are inserted or dropped; /T/, /R/, /I1/ never touched.
// - A minimum gap with two /I2/ pairs can lose four bytes when above half plus the slack.
// - Frames up to 20000 bytes at 1 Gb/s start at half fill.
// - At 100 Mb/s every byte repeats ten times; minimum gap is 80 bytes.
// - At 100 Mb/s two /I2/ pairs of a minimum gap are deletable, one per replicated /I2/.
// - Sustain 20000-byte frames at 1G/100M and 2800 bytes at 10M.
// - Transceiver buffer sustains 9000 bytes at 100M and 900 at 10M.
// - Jumbo frames are received up to the same sustained sizes.
// - Each entry holds one decoded character: one byte plus control flag.
// - Target half mark is 64 entries, with one entry of slack either way.
module rxec_elastic #(
   parameter int DEPTH  = `RXEC_DEPTH,   // Buffer entries
   parameter int ADDR_W = `RXEC_ADDR_W,  // Pointer width
   parameter int HALF   = `RXEC_HALF,    // Target occupancy
   parameter int TOL    = `RXEC_TOL      // Slack around the target
) (
   input  wire logic                 clk,          // System clock
   input  wire logic                 reset_n,      // Synchronous reset, active low
   input  rxec_pkg::rxec_char_t      code_in,      // Decoded character from receive path
   input  wire logic                 code_valid,   // Character present this cycle
   output rxec_pkg::rxec_char_t      rx_char,      // Character to receive state machine
   output logic                      rx_valid,     // rx_char holds a character
   input  wire logic                 rx_ready,     // Receiver takes rx_char
   output logic [ADDR_W:0]           fill_reg,     // Occupancy of the buffer
   output logic                      overflow_reg, // Pulse: character lost, buffer full
   output logic                      starved_reg,  // Pulse: buffer ran empty while primed
   output logic                      in_gap_reg    // Write side is between frames
);
   import rxec_pkg::*;

   localparam logic [ADDR_W:0] HIGH_MARK = (ADDR_W+1)'(HALF + TOL);
   localparam logic [ADDR_W:0] LOW_MARK  = (ADDR_W+1)'(HALF - TOL);
   localparam logic [ADDR_W:0] FULL_MARK = (ADDR_W+1)'(DEPTH);

   rxec_char_t       mem [DEPTH];
   rxec_char_t       pend_reg;
   logic             pend_valid_reg;
   logic [ADDR_W:0]  wr_ptr_reg;
   logic [ADDR_W:0]  rd_ptr_reg;
   logic [ADDR_W:0]  fill_now;
   logic             full;
   logic             empty;
   logic             i2_tail;
   logic             drop;
   logic             wr_en;
   logic             primed_reg;
   logic             last_k28_reg;
   rxec_rd_state_t   rd_state_reg;
   rxec_rd_state_t   rd_state_next;
   logic             rd_fire;
   logic             pop;
   logic             boundary;
   rxec_char_t       head;

   rxec_stream_if    buf_s ();

   ////////////////////////////////////////////////////////////////////////////
   // Occupancy, one entry per decoded character
   assign fill_now = wr_ptr_reg - rd_ptr_reg;
   assign full     = (fill_now == FULL_MARK);
   assign empty    = (fill_now == '0);

   // Pending K28.5 paired with an incoming D16.2 forms an /I2/
   assign i2_tail = pend_valid_reg && pend_reg.is_k && pend_reg.data == `RXEC_K28_5
                    && code_valid && !code_in.is_k && code_in.data == `RXEC_D16_2;
   // Drop the whole pair only in a gap and only above the upper slack
   // Works per /I2/, so replicated bytes at lower speeds need no mode input
   assign drop    = i2_tail && in_gap_reg && (fill_now > HIGH_MARK);
   assign wr_en   = code_valid && pend_valid_reg && !drop;

   ////////////////////////////////////////////////////////////////////////////
   // Frame tracking on the write side: /S/ opens, /T/ closes
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         in_gap_reg <= 1'b1;
      end else if (code_valid && code_in.is_k && code_in.data == `RXEC_K27_7) begin
         in_gap_reg <= 1'b0;
      end else if (code_valid && code_in.is_k && code_in.data == `RXEC_K29_7) begin
         in_gap_reg <= 1'b1;
      end
   end

   // One-character hold so an /I2/ is seen whole before it is stored
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pend_reg       <= `RXEC_CHAR_RST;
         pend_valid_reg <= 1'b0;
      end else if (drop) begin
         pend_valid_reg <= 1'b0;
      end else if (code_valid) begin
         pend_reg       <= code_in;
         pend_valid_reg <= 1'b1;
      end
   end

   // Write pointer; a write into a full buffer is lost and flagged
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wr_ptr_reg   <= `RXEC_PTR_RST;
         overflow_reg <= 1'b0;
      end else begin
         overflow_reg <= wr_en && full;
         if (wr_en && !full) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
      end
   end

   // Storage array
   always_ff @(posedge clk) begin
      if (wr_en && !full) begin
         mem[wr_ptr_reg[ADDR_W-1:0]] <= pend_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read side feeding the two-entry buffer
   assign head  = mem[rd_ptr_reg[ADDR_W-1:0]];
   always_comb begin
      buf_s.valid = 1'b0;
      buf_s.chr   = head;
      case (rd_state_reg)
         RD_INS_K: begin
            buf_s.valid = 1'b1;
            buf_s.chr   = '{is_k: 1'b1, data: `RXEC_K28_5};
         end
         RD_INS_D: begin
            buf_s.valid = 1'b1;
            buf_s.chr   = '{is_k: 1'b0, data: `RXEC_D16_2};
         end
         default: begin
            buf_s.valid = primed_reg && !empty;
         end
      endcase
   end
   assign rd_fire  = buf_s.valid && buf_s.ready;
   assign pop      = rd_fire && rd_state_reg == RD_PASS;
   // An /I2/ just left the buffer or was just inserted: a safe insertion point
   assign boundary = rd_fire && ((rd_state_reg == RD_PASS && last_k28_reg && !head.is_k
                     && head.data == `RXEC_D16_2) || rd_state_reg == RD_INS_D);

   // Next read state: keep inserting idle pairs while below the lower slack
   always_comb begin
      rd_state_next = rd_state_reg;
      case (rd_state_reg)
         RD_PASS: begin
            if (boundary && (fill_now - (ADDR_W+1)'(1)) < LOW_MARK) begin
               rd_state_next = RD_INS_K;
            end
         end
         RD_INS_K: begin
            if (rd_fire) begin
               rd_state_next = RD_INS_D;
            end
         end
         RD_INS_D: begin
            if (rd_fire) begin
               rd_state_next = (fill_now < LOW_MARK) ? RD_INS_K : RD_PASS;
            end
         end
         default: begin
            rd_state_next = RD_PASS;
         end
      endcase
   end

   // Read state register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rd_state_reg <= RD_PASS;
      end else begin
         rd_state_reg <= rd_state_next;
      end
   end

   // Read pointer and idle tracking of the last character popped
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rd_ptr_reg   <= `RXEC_PTR_RST;
         last_k28_reg <= 1'b0;
      end else if (pop) begin
         rd_ptr_reg   <= rd_ptr_reg + 1'b1;
         last_k28_reg <= head.is_k && head.data == `RXEC_K28_5;
      end
   end

   // Reads start once the buffer reaches half; running dry re-primes it
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         primed_reg  <= 1'b0;
         starved_reg <= 1'b0;
      end else begin
         starved_reg <= primed_reg && empty && rd_state_reg == RD_PASS && buf_s.ready;
         if (primed_reg && empty && rd_state_reg == RD_PASS && buf_s.ready) begin
            primed_reg <= 1'b0;
         end else if (fill_now >= (ADDR_W+1)'(HALF)) begin
            primed_reg <= 1'b1;
         end
      end
   end

   // Registered occupancy for observation
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         fill_reg <= '0;
      end else begin
         fill_reg <= fill_now;
      end
   end

   // Two-entry buffer toward the receiver
   rxec_skid u_skid (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_s      (buf_s),
      .out_char  (rx_char),
      .out_valid (rx_valid),
      .out_ready (rx_ready)
   );

   ////////////////////////////////////////////////////////////////////////////
   a_drop_in_gap : assert property (@(posedge clk) disable iff (!reset_n)
      drop |-> (in_gap_reg && fill_now > HIGH_MARK))
      else $error("idle pair dropped outside a gap or below the upper mark");
   a_drop_stores_none : assert property (@(posedge clk) disable iff (!reset_n)
      drop |=> (!pend_valid_reg && wr_ptr_reg == $past(wr_ptr_reg)))
      else $error("dropped idle pair left a character behind");
   a_write_advance : assert property (@(posedge clk) disable iff (!reset_n)
      (wr_en && !full) |=> (wr_ptr_reg == $past(wr_ptr_reg) + 1'b1))
      else $error("write pointer did not advance by one");
   a_overflow_flag : assert property (@(posedge clk) disable iff (!reset_n)
      (wr_en && full) |=> (overflow_reg && wr_ptr_reg == $past(wr_ptr_reg)))
      else $error("full buffer accepted a character");
   a_insert_when_low : assert property (@(posedge clk) disable iff (!reset_n)
      (rd_state_reg == RD_PASS ##1 rd_state_reg == RD_INS_K) |-> $past(fill_now) <= LOW_MARK)
      else $error("insertion started at or above half");
   a_insert_pair : assert property (@(posedge clk) disable iff (!reset_n)
      (rd_state_reg == RD_INS_K && rd_fire) |=> (rd_state_reg == RD_INS_D && buf_s.valid))
      else $error("inserted K28.5 not followed by D16.2");
   a_insert_holds_ptr : assert property (@(posedge clk) disable iff (!reset_n)
      (rd_state_reg != RD_PASS) |=> (rd_ptr_reg == $past(rd_ptr_reg)))
      else $error("read pointer moved during insertion");
   a_prime_hold : assert property (@(posedge clk) disable iff (!reset_n)
      (!primed_reg && rd_state_reg == RD_PASS) |-> !buf_s.valid)
      else $error("read before the buffer reached half");
endmodule

// ===== verif/rxec_src_model.sv
`timescale 1ns/1ns
`include "rxec_map.svh"
////////////////////////////////////////////////////////////////////////
// Receive-path stand-in: sends frames and idles, notes expected characters
module rxec_src_model (
   input  wire logic            clk,        // System clock
   output rxec_pkg::rxec_char_t code_in,    // Decoded character
   output logic                 code_valid  // Character present this cycle
);
   import rxec_pkg::*;
   rxec_char_t exp_q[$];      // Characters the receiver must see, idle pairs left out
   logic       last_k;        // Previous character sent was K28.5
   int         vld_pct = 100; // Chance in percent of a valid cycle

   // Quiet bus at time zero
   initial begin
      code_in    = '0;
      code_valid = 1'b0;
      last_k     = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // One character after random stalls; a stalled bus shows a changing pattern
   task automatic put(input logic k, input logic [7:0] d);
      @(posedge clk);
      for (int s = 0; s < 16 && $urandom_range(99) >= vld_pct; s++) begin
         code_valid <= 1'b0;
         code_in    <= ~code_in;
         @(posedge clk);
      end
      code_valid <= 1'b1;
      code_in    <= '{is_k: k, data: d};
      if (last_k && !k && d == `RXEC_D16_2) void'(exp_q.pop_back()); // Idle pair may vanish
      else exp_q.push_back('{is_k: k, data: d});
      last_k = k && d == `RXEC_K28_5;
   endtask

   // Start, then random bytes each repeated rep times, as at lower speeds
   task automatic frame(input int len, input int rep);
      logic [7:0] b;
      put(1'b1, `RXEC_K27_7);
      repeat (len) begin
         b = 8'($urandom);
         repeat (rep) put(1'b0, b);
      end
   endtask

   // End, carrier extend, then one /I1/ that has to pass untouched
   task automatic tail();
      put(1'b1, `RXEC_K29_7);
      put(1'b1, 8'hF7);
      put(1'b1, `RXEC_K28_5);
      put(1'b0, 8'hC5);
   endtask

   // Idle pairs; tail plus two pairs is the shortest gap of eight bytes
   task automatic gap(input int n);
      repeat (n) begin
         put(1'b1, `RXEC_K28_5);
         put(1'b0, `RXEC_D16_2);
      end
   endtask

   // Release the bus
   task automatic stop();
      @(posedge clk);
      code_valid <= 1'b0;
      code_in    <= ~code_in;
   endtask
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ns
`include "rxec_map.svh"
////////////////////////////////////////////////////////////////////////
module testbench;
   import rxec_pkg::*;
   logic       clk = 1'b0;
   logic       reset_n = 1'b0;
   rxec_char_t code_in;
   rxec_char_t rx_char;
   logic       code_valid;
   logic       rx_valid;
   logic       rx_ready;
   logic [7:0] fill_reg;
   logic       overflow_reg;
   logic       starved_reg;
   logic       in_gap_reg;
   logic       chk_on = 1'b1;
   logic       held = 1'b0;
   logic       ovf_seen = 1'b0;
   logic       stv_seen = 1'b0;
   logic [7:0] f0;
   int         num_errors = 0;
   int         checks_done = 0;
   int         rdy_pct = 100;
   int         n;

   // 50 MHz clock
   always #10 clk = ~clk;

   rxec_elastic i_rxec_elastic (
      .clk          (clk),
      .reset_n      (reset_n),
      .code_in      (code_in),
      .code_valid   (code_valid),
      .rx_char      (rx_char),
      .rx_valid     (rx_valid),
      .rx_ready     (rx_ready),
      .fill_reg     (fill_reg),
      .overflow_reg (overflow_reg),
      .starved_reg  (starved_reg),
      .in_gap_reg   (in_gap_reg)
   );
   rxec_src_model i_rxec_src_model (
      .clk        (clk),
      .code_in    (code_in),
      .code_valid (code_valid)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Fill within the slack around half, allowing for the report lag
   function automatic logic band();
      return fill_reg >= 8'(`RXEC_HALF - `RXEC_TOL - 2) && fill_reg <= 8'(`RXEC_HALF + `RXEC_TOL + 2);
   endfunction

   task automatic pop_cmp(input logic [8:0] c);
      if (i_rxec_src_model.exp_q.size() == 0) check(c, 9'h1FF);
      else check(c, i_rxec_src_model.exp_q.pop_front());
   endtask

   // Strip idle pairs, added or not, and compare everything else in order
   task automatic take(input logic [8:0] c);
      if (held) begin
         held = 1'b0;
         if (c === {1'b0, `RXEC_D16_2}) return;
         pop_cmp({1'b1, `RXEC_K28_5});
      end
      if (c === {1'b1, `RXEC_K28_5}) held = 1'b1;
      else pop_cmp(c);
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Receiver pace
   always @(posedge clk) rx_ready <= ($urandom_range(99) < rdy_pct);

   // Output watcher and sticky flags
   always @(posedge clk) begin
      if (overflow_reg === 1'b1) ovf_seen <= 1'b1;
      if (starved_reg === 1'b1) stv_seen <= 1'b1;
      if (reset_n && chk_on && rx_valid === 1'b1 && rx_ready) take(rx_char);
   end

   // Test sequence
   initial begin
      void'($urandom(32'h8243));
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      i_rxec_src_model.gap(80);
      #1 check({8'b0, band()}, 9'h001);
      $display("test prime done");
      rdy_pct = 30;
      i_rxec_src_model.frame(40, 1);
      i_rxec_src_model.tail();
      i_rxec_src_model.gap(2);
      rdy_pct = 100;
      i_rxec_src_model.frame(30, 1);
      #1 f0 = fill_reg;
      check({8'b0, in_gap_reg}, 9'h000);
      i_rxec_src_model.tail();
      i_rxec_src_model.gap(2);
      check({8'b0, in_gap_reg}, 9'h001);
      i_rxec_src_model.frame(12, 1);
      #1 check({1'b0, fill_reg}, {1'b0, f0 - 8'd4});
      i_rxec_src_model.tail();
      i_rxec_src_model.gap(20);
      #1 check({8'b0, band()}, 9'h001);
      $display("test delete done");
      i_rxec_src_model.vld_pct = 50;
      i_rxec_src_model.frame(30, 1);
      i_rxec_src_model.vld_pct = 100;
      i_rxec_src_model.tail();
      i_rxec_src_model.gap(40);
      #1 check({8'b0, band()}, 9'h001);
      $display("test insert done");
      rdy_pct = 0;
      i_rxec_src_model.frame(5, 10);
      rdy_pct = 100;
      i_rxec_src_model.tail();
      i_rxec_src_model.gap(38);
      i_rxec_src_model.frame(4, 10);
      #1 check({8'b0, band()}, 9'h001);
      check({8'b0, ovf_seen | stv_seen}, 9'h000);
      $display("test slow gap done");
      chk_on = 1'b0;
      rdy_pct = 0;
      i_rxec_src_model.frame(80, 1);
      i_rxec_src_model.stop();
      #1 check({8'b0, ovf_seen}, 9'h001);
      rdy_pct = 100;
      for (n = 0; n < 400 && stv_seen !== 1'b1; n++) @(posedge clk);
      check({8'b0, stv_seen}, 9'h001);
      $display("test overflow and drain done");
      close_out();
   end
endmodule
